// File: core/dht_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dht_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // outside world
  input  wire logic        debug_halt,
  input  wire logic        rtc_clk_in,
  input  wire logic [1:0]  cap_pin_in,
  output dht_pkg::dht_pin_t [1:0] pins,
  output logic             irq
);
  // synchronisers: pins, debug, rtc clock
  logic [1:0] cap_s1, cap_s2, cap_d;
  logic       rtc_s1, rtc_s2, rtc_d, dbg_s1, dbg_s2;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cap_s1 <= 2'h0;
      cap_s2 <= 2'h0;
      cap_d  <= 2'h0;
      rtc_s1 <= 1'b0;
      rtc_s2 <= 1'b0;
      rtc_d  <= 1'b0;
      dbg_s1 <= 1'b0;
      dbg_s2 <= 1'b0;
    end else begin
      cap_s1 <= cap_pin_in;
      cap_s2 <= cap_s1;
      cap_d  <= cap_s2;
      rtc_s1 <= rtc_clk_in;
      rtc_s2 <= rtc_s1;
      rtc_d  <= rtc_s2;
      dbg_s1 <= debug_halt;
      dbg_s2 <= dbg_s1;
    end
  end

  // registers
  logic [31:0] cfg, ctrl, imask, raw;
  logic [31:0] load [2];
  logic [31:0] match [2];
  logic [7:0]  pre [2];
  logic [15:0] cnt [2];
  logic [7:0]  pcnt [2];
  logic [15:0] ecnt [2];
  logic [15:0] rtc_div;
  logic        ack;
  logic [31:0] irq_set;
  logic [1:0]  load_wr;
  // merged load word, so an immediate reload sees the value being written
  logic [31:0] wr_merged [2];

  dht_pkg::dht_top_t top;
  logic wide, wr_ok, rd_ok, cfg_wr;
  // RULE10 top config select
  assign top    = dht_pkg::dht_top_t'(cfg[2:0]);
  // RULE1 wide join
  assign wide   = (top != dht_pkg::DHT_TOP_PAIR);
  // writes land on the edge where waitrequest is seen low
  assign wr_ok  = avs_write && ack;
  // read data is fetched one edge early so it stands while wait is low
  assign rd_ok  = avs_read && !ack;
  assign cfg_wr = wr_ok && (avs_address == dht_pkg::DHT_REG_CFG);

  // one wait state: waitrequest drops in the cycle after a request arrives
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end
  assign ack = !avs_waitrequest;

  // byte-enable merge
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // configuration and control writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg   <= dht_pkg::DHT_RESET_ZERO;
      ctrl  <= dht_pkg::DHT_RESET_ZERO;
      imask <= dht_pkg::DHT_RESET_ZERO;
    end else if (wr_ok) begin
      if (avs_address == dht_pkg::DHT_REG_CFG) begin
        cfg <= merge(cfg, avs_writedata, avs_byteenable);
        // RULE9 config disables
        ctrl[dht_pkg::DHT_CTL_EN] <= 1'b0;
        ctrl[dht_pkg::DHT_CTL_HALF + dht_pkg::DHT_CTL_EN] <= 1'b0;
      end else if (avs_address == dht_pkg::DHT_REG_CTRL) begin
        // RULE15 per-half enable
        ctrl <= merge(ctrl, avs_writedata, avs_byteenable);
      end else if (avs_address == dht_pkg::DHT_REG_IMASK) begin
        imask <= merge(imask, avs_writedata, avs_byteenable)
                 & dht_pkg::DHT_IRQ_USED;
      end
    end
  end

  // load, match, prescale per half
  for (genvar h = 0; h < 2; h++) begin : g_regs
    localparam logic [5:0] LA = h ? dht_pkg::DHT_REG_LOAD_B
                                  : dht_pkg::DHT_REG_LOAD_A;
    localparam logic [5:0] MA = h ? dht_pkg::DHT_REG_MATCH_B
                                  : dht_pkg::DHT_REG_MATCH_A;
    localparam logic [5:0] PA = h ? dht_pkg::DHT_REG_PRE_B
                                  : dht_pkg::DHT_REG_PRE_A;
    assign load_wr[h] = wr_ok && (avs_address == LA);
    assign wr_merged[h] = merge(load[h], avs_writedata, avs_byteenable);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        load[h]  <= dht_pkg::DHT_RESET_LOAD;
        match[h] <= dht_pkg::DHT_RESET_ZERO;
        pre[h]   <= 8'h00;
      end else if (wr_ok) begin
        if (avs_address == LA) begin
          load[h] <= wr_merged[h];
        end else if (avs_address == MA) begin
          match[h] <= merge(match[h], avs_writedata, avs_byteenable);
        end else if (avs_address == PA && avs_byteenable[0]) begin
          pre[h] <= avs_writedata[7:0];
        end
      end
    end
  end

  // real-time divider: one tick per DHT_RTC_DIV external rising edges
  logic rtc_tick;
  assign rtc_tick = rtc_s2 && !rtc_d && (rtc_div == 16'h0000);

  // the two halves
  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam int CB = h * dht_pkg::DHT_CTL_HALF;
    localparam int IB = h * 8;
    dht_pkg::dht_mode_t mode;
    dht_pkg::dht_edge_t edg;
    logic en, run, tick, rise, fall, evt, zero, pwm_lvl, spent;
    // RULE22 wide uses first half controls
    assign en   = ctrl[CB + dht_pkg::DHT_CTL_EN] && !(wide && h == 1);
    // RULE11 per-half mode
    assign mode = dht_pkg::dht_mode_t'(cfg[4 + h*4 +: 3]);
    assign edg  = dht_pkg::dht_edge_t'(ctrl[CB + dht_pkg::DHT_CTL_EDGE +: 2]);
    // RULE13 debug freeze
    assign run  = en && !(dbg_s2 && ctrl[CB + dht_pkg::DHT_CTL_FRZ]);
    // RULE18 prescaler 16-bit only
    assign tick = run && (wide || pcnt[h] == 8'h00);
    assign rise = cap_s2[h] && !cap_d[h];
    assign fall = !cap_s2[h] && cap_d[h];
    // RULE6 edge select
    assign evt  = (edg != dht_pkg::DHT_E_FALL && rise) ||
                  (edg != dht_pkg::DHT_E_RISE && fall);
    assign zero = (h == 0 && wide) ? ({cnt[1], cnt[0]} == 32'h0000_0000)
                                   : (cnt[h] == 16'h0000);

    // prescale divider
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        pcnt[h] <= 8'h00;
      end else if (!run || pcnt[h] == 8'h00) begin
        pcnt[h] <= pre[h];
      end else begin
        pcnt[h] <= pcnt[h] - 8'h01;
      end
    end

    // RULE2 a one-shot fires once, then rests until reloaded or re-enabled
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        spent <= 1'b0;
      end else if (load_wr[h] || !en) begin
        spent <= 1'b0;
      end else if (tick && zero && (wide ? top == dht_pkg::DHT_TOP_WIDE1
                                         : mode == dht_pkg::DHT_M_ONE)) begin
        spent <= 1'b1;
      end
    end

    // counter; the second half is the upper word when wide
    // each process writes only its own half, so no word has two drivers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        cnt[h]  <= 16'hFFFF;
        ecnt[h] <= 16'h0000;
      end else if (cfg_wr) begin
        // a new configuration restarts every count from zero
        cnt[h]  <= 16'h0000;
        ecnt[h] <= 16'h0000;
      end else if (h == 1 && wide) begin
        // upper word follows the first half
        if (load_wr[0]) begin
          cnt[h] <= (top == dht_pkg::DHT_TOP_RTC) ? 16'h0000
                                                  : wr_merged[0][31:16];
        end else if (g_half[0].tick && g_half[0].zero
                     && top == dht_pkg::DHT_TOP_WIDEP) begin
          cnt[h] <= load[0][31:16];
        end else if (top == dht_pkg::DHT_TOP_RTC) begin
          if (g_half[0].run && rtc_tick && cnt[0] == 16'hFFFF) begin
            cnt[h] <= cnt[h] + 16'h0001;
          end
        end else if (g_half[0].tick && !g_half[0].zero
                     && cnt[0] == 16'h0000) begin
          cnt[h] <= cnt[h] - 16'h0001;
        end
      end else if (load_wr[h] && mode != dht_pkg::DHT_M_CCNT) begin
        // RULE17 immediate load
        cnt[h] <= (h == 0 && top == dht_pkg::DHT_TOP_RTC) ? 16'h0000
                                                          : wr_merged[h][15:0];
        ecnt[h] <= 16'h0000;
      end else if (h == 0 && top == dht_pkg::DHT_TOP_RTC) begin
        // RULE4 one count per second
        if (run && rtc_tick) cnt[h] <= cnt[h] + 16'h0001;
      end else if (tick) begin
        if (wide || mode == dht_pkg::DHT_M_ONE
            || mode == dht_pkg::DHT_M_PER || mode == dht_pkg::DHT_M_PWM) begin
          if (zero) begin
            // RULE2 one-shot stops
            // RULE3 periodic reload
            if ((wide && top == dht_pkg::DHT_TOP_WIDEP) ||
                (!wide && mode != dht_pkg::DHT_M_ONE)) begin
              cnt[h] <= load[h][15:0];
            end
          end else begin
            cnt[h] <= cnt[h] - 16'h0001;
          end
        end else if (mode == dht_pkg::DHT_M_CTIM) begin
          // RULE5 time between events
          cnt[h]  <= cnt[h] - 16'h0001;
          if (evt) ecnt[h] <= cnt[h];
        end else if (evt) begin
          // RULE5 event count
          cnt[h] <= cnt[h] + 16'h0001;
        end
      end
    end

    // RULE19 duty from match; RULE7 edge-aligned
    assign pwm_lvl = (cnt[h] > match[h][15:0]);
    // RULE8 event sources
    assign irq_set[IB + 0] = tick && zero && !spent && !(h == 0 && top ==
                             dht_pkg::DHT_TOP_RTC) && (wide ||
                             mode == dht_pkg::DHT_M_ONE ||
                             mode == dht_pkg::DHT_M_PER);
    assign irq_set[IB + 1] = !wide && tick && evt &&
                             mode == dht_pkg::DHT_M_CCNT &&
                             (cnt[h] + 16'h0001 == match[h][15:0]);
    assign irq_set[IB + 2] = !wide && tick && evt &&
                             mode == dht_pkg::DHT_M_CTIM;
    if (h == 0) begin : g_rtc
      assign irq_set[dht_pkg::DHT_IRQ_RTC] = top == dht_pkg::DHT_TOP_RTC &&
        run && {cnt[1], cnt[0]} == match[0];
      assign irq_set[7:4] = 4'h0;
    end else begin : g_pad
      assign irq_set[11] = 1'b0;
      assign irq_set[31:12] = 20'h0_0000;
    end

    // pin outputs all registered
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        pins[h] <= '0;
      end else begin
        // RULE7 pin turns output in pulse mode
        pins[h].pin_oe  <= !wide && en && mode == dht_pkg::DHT_M_PWM;
        // RULE12 polarity
        pins[h].pin_out <= pwm_lvl ^ ctrl[CB + dht_pkg::DHT_CTL_INV];
        // RULE14 trigger gate
        pins[h].trigger <= ctrl[CB + dht_pkg::DHT_CTL_TRG] &&
                           irq_set[IB + 0];
      end
    end
  end

  // rtc prescale divider, counts external rising edges only in real-time mode while the first half runs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_div <= 16'h0000;
    end else if (top != dht_pkg::DHT_TOP_RTC || !g_half[0].run) begin
      rtc_div <= dht_pkg::DHT_RTC_DIV - 16'h0001;
    end else if (rtc_s2 && !rtc_d) begin
      rtc_div <= (rtc_div == 16'h0000) ? dht_pkg::DHT_RTC_DIV - 16'h0001
                                       : rtc_div - 16'h0001;
    end
  end

  // RULE21 sticky flags, set wins over clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      raw <= dht_pkg::DHT_RESET_ZERO;
    end else begin
      if (wr_ok && avs_address == dht_pkg::DHT_REG_ICLR) begin
        raw <= (raw & ~avs_writedata) | irq_set;
      end else begin
        raw <= raw | irq_set;
      end
    end
  end

  // RULE20 masked interrupt line
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(raw & imask);
    end
  end

  // read mux
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= dht_pkg::DHT_RESET_ZERO;
    end else if (rd_ok) begin
      if (avs_address == dht_pkg::DHT_REG_CFG) avs_readdata <= cfg;
      else if (avs_address == dht_pkg::DHT_REG_CTRL) avs_readdata <= ctrl;
      else if (avs_address == dht_pkg::DHT_REG_LOAD_A) avs_readdata <= load[0];
      else if (avs_address == dht_pkg::DHT_REG_LOAD_B) avs_readdata <= load[1];
      else if (avs_address == dht_pkg::DHT_REG_MATCH_A)
        avs_readdata <= match[0];
      else if (avs_address == dht_pkg::DHT_REG_MATCH_B)
        avs_readdata <= match[1];
      else if (avs_address == dht_pkg::DHT_REG_PRE_A)
        avs_readdata <= {24'h00_0000, pre[0]};
      else if (avs_address == dht_pkg::DHT_REG_PRE_B)
        avs_readdata <= {24'h00_0000, pre[1]};
      else if (avs_address == dht_pkg::DHT_REG_IMASK) avs_readdata <= imask;
      else if (avs_address == dht_pkg::DHT_REG_RAW) avs_readdata <= raw;
      else if (avs_address == dht_pkg::DHT_REG_MIS)
        avs_readdata <= raw & imask;
      else if (avs_address == dht_pkg::DHT_REG_VAL_A)
        avs_readdata <= wide ? {cnt[1], cnt[0]} : {16'h0000, cnt[0]};
      else if (avs_address == dht_pkg::DHT_REG_VAL_B)
        avs_readdata <= {ecnt[1], cnt[1]};
      else avs_readdata <= dht_pkg::DHT_BAD_ADDR;
    end
  end
endmodule
`default_nettype wire

// File: include/dht_pkg.sv
// What this block does
// RULE1: two 16-bit halves run alone or join as one 32-bit timer or clock
// RULE2: one-shot counting stops when the count reaches zero
// RULE3: periodic counting reloads at zero and keeps running
// RULE4: real-time mode divides the external 32 kHz clock to one tick a second
// RULE5: capture and pulse modes only in 16-bit width; capture counts edges or time
// RULE6: capture edge choice is rising, falling or both
// RULE7: pulse mode turns the capture pin to an output, edge-aligned
// RULE8: separate flags for capture event, capture match, timeout and clock match
// RULE9: writing the configuration disables both halves and leaves them disabled
// RULE10: top configuration picks wide one-shot, wide periodic, real-time or pair
// RULE11: paired halves each pick one-shot, periodic, edge count, edge time or pulse
// RULE12: per-half polarity makes the pulse output active low when set
// RULE13: debug freeze set stops the half while the processor is halted
// RULE14: per-half trigger enable gates the trigger output
// RULE15: software enables or disables each half; disabled half does nothing
// RULE16: software configures before enabling a half
// RULE17: a load write while running goes into the counter at once; edge-count mode ignores it and real-time mode loads zero instead
// RULE18: prescaler acts only in 16-bit modes
// RULE19: match sets edge-count target and pulse duty
// RULE20: only unmasked flags reach the interrupt line; raw shows all
// RULE21: raw flags stay set until software writes the clear register
// RULE22: in wide modes only the first half's controls matter
package dht_pkg;
  // register word offsets (byte addresses)
  localparam logic [5:0] DHT_REG_CFG     = 6'h00;
  localparam logic [5:0] DHT_REG_CTRL    = 6'h04;
  localparam logic [5:0] DHT_REG_LOAD_A  = 6'h08;
  localparam logic [5:0] DHT_REG_LOAD_B  = 6'h0C;
  localparam logic [5:0] DHT_REG_MATCH_A = 6'h10;
  localparam logic [5:0] DHT_REG_MATCH_B = 6'h14;
  localparam logic [5:0] DHT_REG_PRE_A   = 6'h18;
  localparam logic [5:0] DHT_REG_PRE_B   = 6'h1C;
  localparam logic [5:0] DHT_REG_IMASK   = 6'h20;
  localparam logic [5:0] DHT_REG_RAW     = 6'h24;
  localparam logic [5:0] DHT_REG_MIS     = 6'h28;
  localparam logic [5:0] DHT_REG_ICLR    = 6'h2C;
  localparam logic [5:0] DHT_REG_VAL_A   = 6'h30;
  localparam logic [5:0] DHT_REG_VAL_B   = 6'h34;
  // control bit positions, first half in [7:0], second in [15:8]
  localparam int DHT_CTL_EN   = 0;
  localparam int DHT_CTL_INV  = 1;
  localparam int DHT_CTL_FRZ  = 2;
  localparam int DHT_CTL_TRG  = 3;
  localparam int DHT_CTL_EDGE = 4;  // two bits
  localparam int DHT_CTL_HALF = 8;
  // interrupt bit positions
  localparam int DHT_IRQ_TOUT_A = 0;
  localparam int DHT_IRQ_CMAT_A = 1;
  localparam int DHT_IRQ_CEVT_A = 2;
  localparam int DHT_IRQ_RTC    = 3;
  localparam int DHT_IRQ_TOUT_B = 8;
  localparam int DHT_IRQ_CMAT_B = 9;
  localparam int DHT_IRQ_CEVT_B = 10;
  localparam logic [31:0] DHT_IRQ_USED = 32'h0000_070F;
  localparam logic [31:0] DHT_RESET_LOAD  = 32'hFFFF_FFFF;
  localparam logic [31:0] DHT_RESET_ZERO  = 32'h0000_0000;
  localparam logic [31:0] DHT_BAD_ADDR    = 32'hDEAD_0BAD;
  // external clock ticks per real-time second
  localparam logic [15:0] DHT_RTC_DIV     = 16'h8000;
  // top configuration, cfg[2:0]
  typedef enum logic [2:0] {
    DHT_TOP_PAIR   = 3'b000,
    DHT_TOP_RTC    = 3'b001,
    DHT_TOP_WIDE1  = 3'b010,
    DHT_TOP_WIDEP  = 3'b011
  } dht_top_t;
  // per-half mode, cfg[6:4] first, cfg[10:8] second
  typedef enum logic [2:0] {
    DHT_M_ONE  = 3'b000,
    DHT_M_PER  = 3'b001,
    DHT_M_CCNT = 3'b010,
    DHT_M_CTIM = 3'b011,
    DHT_M_PWM  = 3'b100
  } dht_mode_t;
  typedef enum logic [1:0] {
    DHT_E_RISE = 2'b00,
    DHT_E_FALL = 2'b01,
    DHT_E_BOTH = 2'b11
  } dht_edge_t;
  // per-half pin bundle
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic trigger;
  } dht_pin_t;
endpackage

// File: testbench/dht_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dht_pin_model (
  // clock
  input  wire logic                    clk_sys,
  // pins from the timer
  input  wire dht_pkg::dht_pin_t [1:0] pins,
  // lines into the timer
  output logic [1:0]                   cap_pin_in,
  output logic                         rtc_clk_in
);
  logic [1:0] pad_drv;
  // pin turns output
  // the timer owns the line while its driver is on, else the pad drives
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      cap_pin_in[h] = pins[h].pin_oe ? pins[h].pin_out : pad_drv[h];
    end
  end
  // no real-time source in these runs, so it stands still
  assign rtc_clk_in = 1'b0;
  initial pad_drv = 2'b00;
  // edge stimulus
  // held six cycles so the two-flop sync never misses a level
  task automatic pulse(input int h);
    @(posedge clk_sys);
    pad_drv[h] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    pad_drv[h] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: testbench/dht_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dht_timer_checker (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    sys_rst,
  // register bus
  input wire logic [5:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // outside world
  input wire logic                    debug_halt,
  input wire logic                    rtc_clk_in,
  input wire logic [1:0]              cap_pin_in,
  input wire dht_pkg::dht_pin_t [1:0] pins,
  input wire logic                    irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a request met while the ack flop is still clear
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // a write being taken at one register
  sequence s_wr(logic [5:0] a);
    s_take ##0 (avs_write && avs_address == a && avs_byteenable == 4'hF);
  endsequence
  ack_in_one_a: assert property (s_take |=> !avs_waitrequest)
    else $error("bus answer late");
  ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  idle_wait_a: assert property (
    !(avs_read || avs_write) ##1 !(avs_read || avs_write) |-> avs_waitrequest)
    else $error("wait low while idle");
  bad_read_a: assert property (
    s_take ##0 (avs_read && avs_address > 6'h34)
    |=> avs_readdata == dht_pkg::DHT_BAD_ADDR)
    else $error("unmapped read data wrong");
  trig_pulse0_a: assert property (pins[0].trigger |=> !pins[0].trigger)
    else $error("first trigger too long");
  trig_pulse1_a: assert property (pins[1].trigger |=> !pins[1].trigger)
    else $error("second trigger too long");
  mask_off_a: assert property (
    s_wr(dht_pkg::DHT_REG_IMASK) ##0 (avs_writedata == 32'h0000_0000)
    |-> ##[1:3] !irq)
    else $error("masked irq still high");
  cfg_off_a: assert property (
    s_wr(dht_pkg::DHT_REG_CFG) |-> ##[1:3] (!pins[0].pin_oe && !pins[1].pin_oe))
    else $error("pin driven after config");
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, sys_rst = 1'b1, debug_halt = 1'b0, irq;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, rtc_clk_in;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic [1:0] cap_pin_in;
  logic [15:0] trig_cnt = 16'h0000, t0;
  dht_pkg::dht_pin_t [1:0] pins;
  int n_fail = 0, checks = 0, cyc = 0;
  // clock at 125 MHz
  always #4 clk_sys = ~clk_sys;
  dht_timer dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .debug_halt(debug_halt), .rtc_clk_in(rtc_clk_in),
    .cap_pin_in(cap_pin_in), .pins(pins), .irq(irq));
  dht_pin_model model_u (.clk_sys(clk_sys), .pins(pins),
    .cap_pin_in(cap_pin_in), .rtc_clk_in(rtc_clk_in));
  // trigger pulses of the first half, and a cap on the run length
  always @(posedge clk_sys) begin
    if (pins[0].trigger === 1'b1) trig_cnt <= trig_cnt + 16'h0001;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus cycle: hold until wait is seen low, take data at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // a hang is ended by the run-length cap
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // high cycles of the first pulse pin over one 21-cycle period
  task automatic high_cycles(output int n);
    n = 0;
    repeat (21) begin
      @(posedge clk_sys);
      n += int'(pins[0].pin_out);
    end
  endtask
  task automatic t_reset();
    bus(0, dht_pkg::DHT_REG_RAW, 0); chk("raw", q, 32'h0000_0000);
    bus(0, dht_pkg::DHT_REG_LOAD_A, 0); chk("load", q, dht_pkg::DHT_RESET_LOAD);
    bus(1, 6'h3C, 32'h1234_5678);
    bus(0, 6'h3C, 0); chk("unmapped", q, dht_pkg::DHT_BAD_ADDR);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0101);
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0000);
    bus(0, dht_pkg::DHT_REG_CTRL, 0); chk("ctrl", q & 32'h0000_0101, 0);
    $display("test reset done");
  endtask
  task automatic t_one_shot();
    bus(1, dht_pkg::DHT_REG_PRE_A, 0);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_0014);
    bus(1, dht_pkg::DHT_REG_IMASK, 0);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0001);
    wt(40);
    bus(0, dht_pkg::DHT_REG_RAW, 0); chk("tout", q[0], 1);
    chk("irq masked", irq, 0);
    bus(1, dht_pkg::DHT_REG_IMASK, 32'h0000_0001);
    wt(3); chk("irq", irq, 1);
    bus(1, dht_pkg::DHT_REG_IMASK, 0);
    wt(20); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("sticky", q[0], 1);
    bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_0001);
    wt(60); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("stopped", q[0], 0);
    $display("test one_shot done");
  endtask
  task automatic t_periodic();
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0010);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_001E);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0009);
    t0 = trig_cnt;
    wt(200); chk("trig on", 32'(trig_cnt - t0 >= 5), 1);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0001);
    wt(2);
    t0 = trig_cnt;
    wt(100); chk("trig off", 32'(trig_cnt - t0), 0);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_4000);
    bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_0001);
    wt(100); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("reload", q[0], 0);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_001E);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0005);
    debug_halt <= 1'b1;
    wt(10); bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_0001);
    wt(100); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("frozen", q[0], 0);
    debug_halt <= 1'b0;
    wt(100); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("thawed", q[0], 1);
    $display("test periodic done");
  endtask
  task automatic t_capture();
    dht_pkg::dht_edge_t e;
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? dht_pkg::DHT_E_RISE :
          (i == 1) ? dht_pkg::DHT_E_FALL : dht_pkg::DHT_E_BOTH;
      bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0020);
      bus(1, dht_pkg::DHT_REG_MATCH_A, 32'h0000_0003);
      bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_070F);
      bus(1, dht_pkg::DHT_REG_CTRL, {24'h0, 2'b00, e, 4'b0001});
      repeat (3) model_u.pulse(0);
      bus(0, dht_pkg::DHT_REG_VAL_A, 0);
      chk("edges", q[15:0], (i == 2) ? 6 : 3);
      bus(0, dht_pkg::DHT_REG_RAW, 0); chk("cap flags", q[2:1], 2'b01);
    end
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0030);
    bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_070F);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0001);
    model_u.pulse(0);
    bus(0, dht_pkg::DHT_REG_RAW, 0); chk("cap event", q[2], 1);
    $display("test capture done");
  endtask
  task automatic t_pwm();
    int n;
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0440);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_0014);
    bus(1, dht_pkg::DHT_REG_MATCH_A, 32'h0000_000A);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0001);
    wt(5); chk("oe a", pins[0].pin_oe, 1);
    chk("oe b", pins[1].pin_oe, 0);
    high_cycles(n); chk("duty", n, 10);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0003);
    wt(2); high_cycles(n); chk("inverted", n, 11);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0100);
    wt(5); chk("oe a off", pins[0].pin_oe, 0);
    chk("oe b on", pins[1].pin_oe, 1);
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0000);
    wt(5); chk("oe b cfg", pins[1].pin_oe, 0);
    $display("test pwm done");
  endtask
  // joined halves ignore the prescaler and the second half's enable
  task automatic t_wide();
    bus(1, dht_pkg::DHT_REG_CFG, 32'h0000_0003);
    bus(1, dht_pkg::DHT_REG_PRE_A, 32'h0000_00FF);
    bus(1, dht_pkg::DHT_REG_LOAD_A, 32'h0000_0020);
    bus(1, dht_pkg::DHT_REG_ICLR, 32'h0000_070F);
    bus(1, dht_pkg::DHT_REG_CTRL, 32'h0000_0101);
    wt(80); bus(0, dht_pkg::DHT_REG_RAW, 0); chk("wide tout", q[0], 1);
    chk("wide b", q[8], 0);
    $display("test wide done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_one_shot();
    t_periodic();
    t_capture();
    t_pwm();
    t_wide();
    end_of_test();
  end
endmodule
bind dht_timer dht_timer_checker chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .debug_halt(debug_halt), .rtc_clk_in(rtc_clk_in),
  .cap_pin_in(cap_pin_in), .pins(pins), .irq(irq));
`default_nettype wire
